// ==== hdl/pvc_pkg.sv ====
// Purpose : Shared constants, types and register map of the preamp control bank
// Assumes : Byte-wide registers on a 16-bit register address space
// Notes   : Register addresses and masks live here only

package pvc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          NUM_REGS   = 10;
    localparam logic [15:0] ADDR_FADE  = 16'h8429;
    localparam logic [15:0] ADDR_BLUE  = 16'h8430;
    localparam logic [15:0] ADDR_GREEN = 16'h8431;
    localparam logic [15:0] ADDR_RED   = 16'h8432;
    localparam logic [15:0] ADDR_CONTR = 16'h8433;
    localparam logic [15:0] ADDR_CONV1 = 16'h8434;
    localparam logic [15:0] ADDR_CONV2 = 16'h8435;
    localparam logic [15:0] ADDR_CONV3 = 16'h8436;
    localparam logic [15:0] ADDR_CONV4 = 16'h8437;
    localparam logic [15:0] ADDR_CFG   = 16'h8438;

    // Cell indices
    localparam int IDX_FADE  = 0;
    localparam int IDX_BLUE  = 1;
    localparam int IDX_GREEN = 2;
    localparam int IDX_RED   = 3;
    localparam int IDX_CONTR = 4;
    localparam int IDX_CONV1 = 5;
    localparam int IDX_CONV2 = 6;
    localparam int IDX_CONV3 = 7;
    localparam int IDX_CONV4 = 8;
    localparam int IDX_CFG   = 9;

    // Writable bits; reserved bits are stored and read as zero
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_LOW7 = 8'h7f;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    localparam logic [15:0] REG_ADDR [NUM_REGS] = '{
        ADDR_FADE, ADDR_BLUE, ADDR_GREEN, ADDR_RED, ADDR_CONTR,
        ADDR_CONV1, ADDR_CONV2, ADDR_CONV3, ADDR_CONV4, ADDR_CFG};
    localparam logic [7:0] REG_MASK [NUM_REGS] = '{
        MASK_FULL, MASK_LOW7, MASK_LOW7, MASK_LOW7, MASK_LOW7,
        MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL, MASK_LOW7};

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FADE_V_HI = 7;
    localparam int FADE_V_LO = 4;
    localparam int FADE_H_HI = 3;
    localparam int FADE_H_LO = 0;
    localparam int GAIN_HI   = 6;
    localparam int CFG_OPT_HI   = 6;
    localparam int CFG_OPT_LO   = 5;
    localparam int CFG_MIX_BIT  = 6;
    localparam int CFG_RANGE_BIT = 5;
    localparam int CFG_OSD_HI   = 4;
    localparam int CFG_OSD_LO   = 3;
    localparam int CFG_DC_HI    = 2;
    localparam int CFG_DC_LO    = 0;

    // ----------------------------------------------------------------
    // Serial bus framing
    // ----------------------------------------------------------------
    localparam logic [2:0] BIT_FIRST  = 3'h0;
    localparam logic [2:0] BIT_LAST   = 3'h7;
    localparam logic [2:0] BIT_STEP   = 3'h1;
    localparam logic [1:0] BYTE_DEV   = 2'h0;
    localparam logic [1:0] BYTE_PHI   = 2'h1;
    localparam logic [1:0] BYTE_PLO   = 2'h2;
    localparam logic [1:0] BYTE_DATA  = 2'h3;
    localparam logic [1:0] BYTE_STEP  = 2'h1;
    localparam logic [15:0] PTR_STEP  = 16'h0001;
    localparam logic [15:0] PTR_RESET = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RX    = 3'b001,
        ST_ACK   = 3'b010,
        ST_TX    = 3'b011,
        ST_TXACK = 3'b100
    } pvc_state_t;

    // Levels presented to the analog circuits
    typedef struct packed {
        logic [3:0] vertical_fade_span;
        logic [3:0] horizontal_fade_span;
        logic [6:0] blue_gain_code;
        logic [6:0] green_gain_code;
        logic [6:0] red_gain_code;
        logic [6:0] common_contrast_code;
        logic [7:0] converter_one_code;
        logic [7:0] converter_two_code;
        logic [7:0] converter_three_code;
        logic [7:0] converter_four_code;
        logic [1:0] converter_option_field;
        logic       converter_range_alt;
        logic       converter_four_mix;
        logic [1:0] overlay_contrast;
        logic [2:0] video_level_shift;
    } pvc_analog_t;

endpackage : pvc_pkg

// ==== hdl/pvc_pin_edge.sv ====
// Purpose : Edge detect for a bus pin already synchronous to clk_sys
// Assumes : Pin input is sampled directly, no synchroniser needed
// Notes   : Rise and fall are single-cycle pulses

`timescale 1ns/1ps

module pvc_pin_edge (
    input  wire logic clk_sys,  // System clock
    input  wire logic reset,    // Synchronous reset, high
    input  wire logic pinIn,    // Pin level
    output logic      pinPrev,  // Level one cycle ago
    output logic      pinRise,  // Rising edge pulse
    output logic      pinFall   // Falling edge pulse
);

    logic next_pinPrev;

    // ----------------------------------------------------------------
    // Edge logic
    // ----------------------------------------------------------------
    // Idle bus is high, so reset to high avoids a false fall
    always_comb begin
        next_pinPrev = pinIn;
        pinRise      = pinIn & ~pinPrev;
        pinFall      = ~pinIn & pinPrev;
    end

    // History register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pinPrev <= 1'b1;
        end else begin
            pinPrev <= next_pinPrev;
        end
    end

endmodule : pvc_pin_edge

// ==== hdl/pvc_reg_cell.sv ====
// Purpose : One byte-wide control register with reserved-bit mask
// Assumes : Write enable is a single-cycle strobe
// Notes   : Masked bits are stored as zero, so they read back as zero

`timescale 1ns/1ps

module pvc_reg_cell #(
    parameter logic [7:0] MASK  = 8'hff, // Writable bits
    parameter logic [7:0] RESET = 8'h00  // Value after reset
) (
    input  wire logic       clk_sys,  // System clock
    input  wire logic       reset,    // Synchronous reset, high
    input  wire logic       wrEn,     // Write strobe
    input  wire logic [7:0] wrData,   // Write byte
    output logic      [7:0] value     // Stored byte
);

    logic [7:0] next_value;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    // Hold until the next write; reserved bits are dropped
    always_comb begin
        next_value = value;
        if (wrEn) begin
            next_value = wrData & MASK;
        end
    end

    // Register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            value <= RESET & MASK;
        end else begin
            value <= next_value;
        end
    end

endmodule : pvc_reg_cell

// ==== hdl/pvc_ctrl_regs.sv ====
// Purpose : Preamp video control register bank behind a two-wire serial slave
// Assumes : scl and sda inputs synchronous to clk_sys, far slower than it
// Notes   : 16-bit register pointer, auto-increment on every data byte

`timescale 1ns/1ps

// Operation
// - Fade register upper nibble holds the vertical fade interval.
// - Fade register lower nibble holds the horizontal fade interval.
// - Blue gain keeps a seven-bit code; top bit reserved.
// - Green gain keeps a seven-bit code; top bit reserved.
// - Red gain keeps a seven-bit code; top bit reserved.
// - Contrast keeps a seven-bit code common to all channels; top bit reserved.
// - Converters one to three hold eight-bit codes; range from config bit five.
// - Converter four holds eight-bit code, optionally scaled and mixed into video.
// - Config: bit7 reserved, option field, overlay contrast, DC offset bits 2-0.
// - Config bit five low picks lower converter range; high picks alternate.
module pvc_ctrl_regs
    import pvc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a // Bus address, arbitrary value
) (
    input  wire logic  clk_sys,    // System clock, 100 MHz
    input  wire logic  reset,      // Synchronous reset, high
    input  wire logic  sclIn,      // Serial clock level
    input  wire logic  sdaIn,      // Serial data line level
    output logic       sdaOut,     // Data drive value, always low
    output logic       sdaOe,      // High while pulling data low
    output pvc_analog_t analogCtrl // Levels to analog circuits
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    pvc_state_t  state;
    pvc_state_t  next_state;
    logic [2:0]  bitCount;
    logic [2:0]  next_bitCount;
    logic [7:0]  shiftReg;
    logic [7:0]  next_shiftReg;
    logic        byteFull;
    logic        next_byteFull;
    logic [1:0]  byteIdx;
    logic [1:0]  next_byteIdx;
    logic        readMode;
    logic        next_readMode;
    logic [15:0] regPtr;
    logic [15:0] next_regPtr;
    logic        next_sdaOe;
    logic        next_sdaOut;
    logic        wrStrobe;
    logic        loadTx;
    logic [7:0]  rdData;
    logic        sclPrev;
    logic        sclRise;
    logic        sclFall;
    logic        sdaPrev;
    logic        sdaRise;
    logic        sdaFall;
    logic        startCond;
    logic        stopCond;
    logic [NUM_REGS-1:0] cellWr;
    logic [7:0]  cellVal [NUM_REGS];

    // ----------------------------------------------------------------
    // Pin edges
    // ----------------------------------------------------------------
    pvc_pin_edge u_scl_edge (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pinIn   (sclIn),
        .pinPrev (sclPrev),
        .pinRise (sclRise),
        .pinFall (sclFall)
    );

    pvc_pin_edge u_sda_edge (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pinIn   (sdaIn),
        .pinPrev (sdaPrev),
        .pinRise (sdaRise),
        .pinFall (sdaFall)
    );

    // Data moving while clock stays high frames a transfer
    assign startCond = sdaFall & sclIn & sclPrev;
    assign stopCond  = sdaRise & sclIn & sclPrev;

    // ----------------------------------------------------------------
    // Register cells
    // ----------------------------------------------------------------
    // reserved bits masked
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_cell
            assign cellWr[gi] = wrStrobe && (regPtr == REG_ADDR[gi]);
            pvc_reg_cell #(
                .MASK  (REG_MASK[gi]),
                .RESET (REG_RESET)
            ) u_cell (
                .clk_sys (clk_sys),
                .reset   (reset),
                .wrEn    (cellWr[gi]),
                .wrData  (shiftReg),
                .value   (cellVal[gi])
            );
        end
    endgenerate

    // Read-back mux; addresses outside the bank answer zero
    always_comb begin
        rdData = UNMAPPED_READ;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (regPtr == REG_ADDR[i]) begin
                rdData = cellVal[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Serial slave sequencer
    // ----------------------------------------------------------------
    // Sample on clock rise, change drive on clock fall
    always_comb begin
        next_state    = state;
        next_bitCount = bitCount;
        next_shiftReg = shiftReg;
        next_byteFull = byteFull;
        next_byteIdx  = byteIdx;
        next_readMode = readMode;
        next_regPtr   = regPtr;
        next_sdaOe    = sdaOe;
        next_sdaOut   = 1'b0;
        wrStrobe      = 1'b0;
        loadTx        = 1'b0;
        if (startCond) begin
            // Repeated start restarts framing, pointer is kept
            next_state    = ST_RX;
            next_bitCount = BIT_FIRST;
            next_byteFull = 1'b0;
            next_byteIdx  = BYTE_DEV;
            next_sdaOe    = 1'b0;
        end else if (stopCond) begin
            next_state = ST_IDLE;
            next_sdaOe = 1'b0;
        end else begin
            case (state)
                ST_RX: begin
                    if (sclRise) begin
                        next_shiftReg = {shiftReg[6:0], sdaIn};
                        next_bitCount = bitCount + BIT_STEP;
                        if (bitCount == BIT_LAST) begin
                            next_byteFull = 1'b1;
                        end
                    end else if (sclFall && byteFull) begin
                        next_byteFull = 1'b0;
                        next_state    = ST_ACK;
                        next_sdaOe    = 1'b1;
                        if (byteIdx != BYTE_DATA) begin
                            next_byteIdx = byteIdx + BYTE_STEP;
                        end
                        case (byteIdx)
                            BYTE_DEV: begin
                                if (shiftReg[7:1] == DEV_ADDR) begin
                                    next_readMode = shiftReg[0];
                                end else begin
                                    // Not ours: stay off the line
                                    next_state = ST_IDLE;
                                    next_sdaOe = 1'b0;
                                end
                            end
                            BYTE_PHI: begin
                                next_regPtr[15:8] = shiftReg;
                            end
                            BYTE_PLO: begin
                                next_regPtr[7:0] = shiftReg;
                            end
                            default: begin
                                wrStrobe    = 1'b1;
                                next_regPtr = regPtr + PTR_STEP;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        next_bitCount = BIT_FIRST;
                        if (readMode) begin
                            loadTx = 1'b1;
                        end else begin
                            next_state = ST_RX;
                            next_sdaOe = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        next_bitCount = bitCount + BIT_STEP;
                        next_shiftReg = {shiftReg[6:0], 1'b0};
                        if (bitCount == BIT_LAST) begin
                            // Release for the master acknowledge
                            next_state = ST_TXACK;
                            next_sdaOe = 1'b0;
                        end else begin
                            next_sdaOe = ~shiftReg[6];
                        end
                    end
                end
                ST_TXACK: begin
                    if (sclRise && sdaIn) begin
                        // No acknowledge ends the read
                        next_state = ST_IDLE;
                    end else if (sclFall) begin
                        loadTx = 1'b1;
                    end
                end
                default: begin
                    next_sdaOe = 1'b0;
                end
            endcase
            if (loadTx) begin
                // Open drain: pull low only for a zero bit
                next_state    = ST_TX;
                next_bitCount = BIT_FIRST;
                next_shiftReg = rdData;
                next_sdaOe    = ~rdData[7];
                next_regPtr   = regPtr + PTR_STEP;
            end
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state    <= ST_IDLE;
            bitCount <= BIT_FIRST;
            shiftReg <= REG_RESET;
            byteFull <= 1'b0;
            byteIdx  <= BYTE_DEV;
            readMode <= 1'b0;
            regPtr   <= PTR_RESET;
            sdaOe    <= 1'b0;
            sdaOut   <= 1'b0;
        end else begin
            state    <= next_state;
            bitCount <= next_bitCount;
            shiftReg <= next_shiftReg;
            byteFull <= next_byteFull;
            byteIdx  <= next_byteIdx;
            readMode <= next_readMode;
            regPtr   <= next_regPtr;
            sdaOe    <= next_sdaOe;
            sdaOut   <= next_sdaOut;
        end
    end

    // ----------------------------------------------------------------
    // Analog control fields
    // ----------------------------------------------------------------
    // Pure wiring from cell flops, so outputs stay registered
    // vertical fade nibble
    assign analogCtrl.vertical_fade_span   = cellVal[IDX_FADE][FADE_V_HI:FADE_V_LO];
    assign analogCtrl.horizontal_fade_span = cellVal[IDX_FADE][FADE_H_HI:FADE_H_LO];
    assign analogCtrl.blue_gain_code       = cellVal[IDX_BLUE][GAIN_HI:0];
    assign analogCtrl.green_gain_code      = cellVal[IDX_GREEN][GAIN_HI:0];
    assign analogCtrl.red_gain_code        = cellVal[IDX_RED][GAIN_HI:0];
    assign analogCtrl.common_contrast_code = cellVal[IDX_CONTR][GAIN_HI:0];
    assign analogCtrl.converter_one_code   = cellVal[IDX_CONV1];
    assign analogCtrl.converter_two_code   = cellVal[IDX_CONV2];
    assign analogCtrl.converter_three_code = cellVal[IDX_CONV3];
    assign analogCtrl.converter_four_code  = cellVal[IDX_CONV4];
    assign analogCtrl.converter_option_field = cellVal[IDX_CFG][CFG_OPT_HI:CFG_OPT_LO];
    assign analogCtrl.overlay_contrast       = cellVal[IDX_CFG][CFG_OSD_HI:CFG_OSD_LO];
    assign analogCtrl.video_level_shift      = cellVal[IDX_CFG][CFG_DC_HI:CFG_DC_LO];
    assign analogCtrl.converter_range_alt    = cellVal[IDX_CFG][CFG_RANGE_BIT];
    assign analogCtrl.converter_four_mix     = cellVal[IDX_CFG][CFG_MIX_BIT];

endmodule : pvc_ctrl_regs

// ==== verification/pvc_ctrl_regs_chk.sv ====
// Purpose: Port-level checks of the preamp control bank
// Assumes: Sees only the ports of pvc_ctrl_regs
// Notes  : Bound from the testbench top file
`timescale 1ns/1ps
module pvc_ctrl_regs_chk
    import pvc_pkg::*;
(
    input wire logic        clk_sys,   // System clock
    input wire logic        reset,     // Sync reset, high
    input wire logic        sclIn,     // Serial clock level
    input wire logic        sdaIn,     // Data line level
    input wire logic        sdaOut,    // Data drive value
    input wire logic        sdaOe,     // Data pull enable
    input wire pvc_analog_t analogCtrl // Analog levels
);
    default clocking cb @(posedge clk_sys);
    endclocking
    // Open drain: the device may only pull low
    a_out_low: assert property (disable iff (reset) sdaOut == 1'b0)
        else $error("data drive value not low");
    a_oe_low_phase: assert property (disable iff (reset)
        $changed(sdaOe) |-> !sclIn && !$past(sclIn))
        else $error("data line drive moved while clock high");
    a_oe_after_fall: assert property (disable iff (reset)
        $rose(sdaOe) |-> $past(sclIn, 2) || $past(sclIn, 3) || $past(sclIn, 4))
        else $error("data line drive not tied to clock fall");
    a_oe_release_bound: assert property (disable iff (reset)
        $rose(sdaOe) |-> ##[1:400] !sdaOe)
        else $error("data line held low too long");
    a_ctrl_near_fall: assert property (disable iff (reset)
        $changed(analogCtrl) |-> !sclIn && ($past(sclIn, 2) || $past(sclIn, 3) || $past(sclIn, 4)))
        else $error("analog level changed outside a write");
    a_reset_clear: assert property (reset |=> analogCtrl == '0 && sdaOe == 1'b0)
        else $error("reset did not clear outputs");
    a_range_bit: assert property (disable iff (reset)
        analogCtrl.converter_range_alt == analogCtrl.converter_option_field[0])
        else $error("range flag differs from option bit five");
    a_mix_bit: assert property (disable iff (reset)
        analogCtrl.converter_four_mix == analogCtrl.converter_option_field[1])
        else $error("mix flag differs from option bit six");
endmodule : pvc_ctrl_regs_chk

// ==== verification/pvc_host_model.sv ====
// Purpose: Microcontroller model on the two-wire control bus
// Assumes: Data line pull-up resolved in the testbench
// Notes  : Changes one step after a clock edge; clock stands high when idle
`timescale 1ns/1ps
module pvc_host_model (
    input  wire logic clk_sys, // System clock
    input  wire logic sdaLine, // Resolved data line
    output logic      scl,     // Serial clock drive
    output logic      sdaLow   // High pulls data line low
);
    localparam int HALF = 5; // Margin over the 3-cycle minimum
    initial begin
        scl    = 1'b1;
        sdaLow = 1'b0;
    end
    // Step off the sampling edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    // Start or repeated start
    task automatic start();
        sdaLow = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sdaLow = 1'b1;
        tick(HALF);
        scl = 1'b0;
        tick(1);
    endtask : start
    task automatic stop();
        sdaLow = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sdaLow = 1'b0;
        tick(HALF);
    endtask : stop
    // Data set while clock low, sampled at end of high phase
    task automatic bitx(input logic b, output logic r);
        sdaLow = ~b;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        r   = sdaLine;
        scl = 1'b0;
        tick(1);
    endtask : bitx
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask : send
    // Last byte is refused so the device lets go
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(last, r);
    endtask : recv
endmodule : pvc_host_model

// ==== verification/tb.sv ====
// Purpose: Self-checking bench of the preamp control bank
// Assumes: Host model drives the serial bus; line pulled up here
// Notes  : Bursts sweep the fade register, a hole, then the bank
`timescale 1ns/1ps
module tb
    import pvc_pkg::*;
;
    localparam logic [6:0] DEV = 7'h2a; // Arbitrary bus address
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        sdaOut, sdaOe, scl, sdaLow;
    wire logic   sdaIn = ~(sdaLow | sdaOe); // Pull-up unless pulled
    pvc_analog_t analogCtrl;
    logic [7:0]  regm [NUM_REGS];
    logic [7:0]  wbuf [16];
    int          fails = 0;
    int          samplesChecked = 0;

    always #5 clk_sys = ~clk_sys;

    pvc_ctrl_regs #(.DEV_ADDR(DEV)) u_dut (.clk_sys(clk_sys), .reset(reset), .sclIn(scl),
        .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .analogCtrl(analogCtrl));
    pvc_host_model u_host (.clk_sys(clk_sys), .sdaLine(sdaIn), .scl(scl), .sdaLow(sdaLow));

    // ----------------------------------------------------------------
    // Expectations and compares
    // ----------------------------------------------------------------
    function automatic int idx_of(input logic [15:0] a);
        if (a == ADDR_FADE) return 0;
        if (a >= ADDR_BLUE && a <= ADDR_CFG) return int'(a - ADDR_BLUE) + 1;
        return -1;
    endfunction : idx_of
    // Gains, contrast and config keep bit 7 at zero
    function automatic logic [7:0] mask_of(input int i);
        return (i inside {1, 2, 3, 4, 9}) ? 8'h7f : 8'hff;
    endfunction : mask_of
    function automatic pvc_analog_t exp_ctrl();
        return pvc_analog_t'({regm[0], regm[1][6:0], regm[2][6:0], regm[3][6:0], regm[4][6:0], regm[5],
            regm[6], regm[7], regm[8], regm[9][6:5], regm[9][5], regm[9][6], regm[9][4:0]});
    endfunction : exp_ctrl
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_ctrl(input pvc_analog_t got, input pvc_analog_t exp);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: levels %h, expected %h", $time, got, exp);
        end
    endtask : chk_ctrl
    task automatic put(input logic [7:0] d, input logic expAck);
        logic ack;
        u_host.send(d, ack);
        chk_byte({7'h00, ack}, {7'h00, expAck});
    endtask : put
    // Write burst; a wrong bus address ends after the refused byte
    task automatic wr_frame(input logic [6:0] dev, input logic [15:0] a, input int n);
        int k;
        u_host.start();
        put({dev, 1'b0}, dev == DEV);
        if (dev == DEV) begin
            put(a[15:8], 1'b1);
            put(a[7:0], 1'b1);
            for (int i = 0; i < n; i++) begin
                put(wbuf[i], 1'b1);
                k = idx_of(a + 16'(i));
                if (k >= 0) regm[k] = wbuf[i] & mask_of(k);
            end
        end
        u_host.stop();
    endtask : wr_frame
    task automatic rd_frame(input logic [15:0] a, input int n);
        logic [7:0] d;
        int         k;
        u_host.start();
        put({DEV, 1'b0}, 1'b1);
        put(a[15:8], 1'b1);
        put(a[7:0], 1'b1);
        u_host.start();
        put({DEV, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_host.recv(i == n - 1, d);
            k = idx_of(a + 16'(i));
            chk_byte(d, (k >= 0) ? regm[k] : 8'h00);
        end
        u_host.stop();
    endtask : rd_frame
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    // Whole run is about 25000 cycles
    initial begin
        repeat (80000) @(posedge clk_sys);
        fails++;
        end_sim();
    end

    // Main sequence
    initial begin
        logic [7:0] cfgv [3];
        cfgv = '{8'h20, 8'h40, 8'h9f};
        void'($urandom(32'h34a00f47));
        foreach (regm[i]) regm[i] = 8'h00;
        repeat (4) @(posedge clk_sys);
        #1 reset = 1'b0;
        u_host.tick(4);
        chk_ctrl(analogCtrl, exp_ctrl());
        rd_frame(ADDR_FADE, 16);
        // All ones, all zeros, then random bursts
        for (int it = 0; it < 5; it++) begin
            foreach (wbuf[j]) wbuf[j] = (it == 0) ? 8'hff : (it == 1) ? 8'h00 : 8'($urandom);
            wr_frame(DEV, ADDR_FADE, 16);
            u_host.tick(20);
            chk_ctrl(analogCtrl, exp_ctrl());
            rd_frame(ADDR_FADE, 16);
        end
        wbuf[0] = 8'h5a;
        wr_frame(DEV ^ 7'h01, ADDR_BLUE, 1);
        chk_ctrl(analogCtrl, exp_ctrl());
        foreach (cfgv[j]) begin
            wbuf[0] = cfgv[j];
            wr_frame(DEV, ADDR_CFG, 1);
            u_host.tick(4);
            chk_ctrl(analogCtrl, exp_ctrl());
        end
        // mid-run reset drops every level back to zero
        reset = 1'b1;
        u_host.tick(2);
        reset = 1'b0;
        foreach (regm[i]) regm[i] = 8'h00;
        u_host.tick(4);
        chk_ctrl(analogCtrl, exp_ctrl());
        rd_frame(ADDR_BLUE, 9);
        // host keeps the reserved bit clear
        wbuf[0] = 8'h15;
        wr_frame(DEV, ADDR_BLUE, 1);
        u_host.tick(4);
        chk_ctrl(analogCtrl, exp_ctrl());
        end_sim();
    end
endmodule : tb

bind pvc_ctrl_regs pvc_ctrl_regs_chk u_chk (.clk_sys(clk_sys), .reset(reset), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .analogCtrl(analogCtrl));
